//--- bbp_consts.svh
// constants for the baseband port: lane counts, framing and timing figures
`ifndef BBP_CONSTS_SVH
`define BBP_CONSTS_SVH
`define BBP_LANES 12
`define BBP_LINKS 3
`define BBP_SAMPLE_W 36
`define BBP_STEP_W 9
`define BBP_FREQ_W 10
`define BBP_STEPS_SERIAL 5'h12
`define BBP_STEPS_NIBBLE 5'h09
`define BBP_STEPS_BYTE 5'h04
`define BBP_BITS_SERIAL 4'h2
`define BBP_BITS_NIBBLE 4'h4
`define BBP_BITS_BYTE 4'h9
`define BBP_LINKS_SERIAL 2'h3
`define BBP_LINKS_NIBBLE 2'h2
`define BBP_LINKS_BYTE 2'h1
`define BBP_HALF_MAX_MHZ 10'd155
`define BBP_SINGLE_MAX_MHZ 10'd310
`define BBP_EDGE_ONLY_MHZ 10'd250
`define BBP_CFG_SETTLE 6'h30
`define BBP_HOST_PHASE_CLK 3'h0
`define BBP_HOST_PHASE_DAT 3'h4
`define BBP_HOST_SAMPLE_DLY 3'h4
`endif

//--- bbp_pkg.sv
// types and lane-mapping helpers shared by both ends of the baseband port
`include "bbp_consts.svh"
package bbp_pkg;
  typedef enum logic [1:0] {edge_aligned_mode, single_rate_centred_mode, half_rate_centred_mode} bbp_mode_t;
  typedef enum logic [1:0] {serial_width, nibble_width, byte_width} bbp_width_t;
  typedef logic [`BBP_LINKS-1:0][`BBP_SAMPLE_W-1:0] bbp_frame_t;
  typedef logic [`BBP_LINKS-1:0][`BBP_STEP_W-1:0] bbp_step_t;

  // ----------------------------------------------------------------
  // state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic err;
    bbp_mode_t mode;
    bbp_width_t width;
    logic [5:0] settle;
    bbp_frame_t hold;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic rdy;
    logic [`BBP_LANES-1:0] in_s1;
    logic [`BBP_LANES-1:0] in_s2;
    logic [`BBP_LANES-1:0] in_prev;
    bbp_frame_t rsh;
    logic [`BBP_LINKS-1:0][4:0] rcnt;
    bbp_frame_t rdat;
    logic [`BBP_LINKS-1:0] rvld;
  } bbp_dev_ref_t;

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    bbp_mode_t mode_s1;
    bbp_mode_t mode_s2;
    bbp_width_t width_s1;
    bbp_width_t width_s2;
    logic req_s1;
    logic req_s2;
    logic ack;
    logic [1:0] q;
    logic [4:0] cnt;
    logic act;
    bbp_frame_t sh;
    bbp_step_t d;
    logic [`BBP_LINKS-1:0] s;
    logic [`BBP_LINKS-1:0] c;
    logic [`BBP_LANES-1:0] lane;
  } bbp_dev_lnk_t;

  typedef struct packed {
    logic en;
    bbp_width_t width;
    logic [3:0] div;
    logic pend;
    bbp_frame_t hold;
    logic rdy;
    logic [4:0] cnt;
    logic act;
    bbp_frame_t sh;
    bbp_step_t d;
    logic [`BBP_LINKS-1:0] s;
    logic [`BBP_LINKS-1:0] c;
    logic [`BBP_LANES-1:0] lane;
    logic [`BBP_LANES-1:0] out_s1;
    logic [`BBP_LANES-1:0] out_s2;
    logic [`BBP_LANES-1:0] out_prev;
    logic [`BBP_LINKS-1:0][2:0] dly;
    bbp_frame_t rsh;
    logic [`BBP_LINKS-1:0][4:0] rcnt;
    bbp_frame_t rdat;
    logic [`BBP_LINKS-1:0] rvld;
  } bbp_host_t;

  // ----------------------------------------------------------------
  // framing helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] frame_steps(input bbp_width_t w);
    unique case (w)
      serial_width: frame_steps = `BBP_STEPS_SERIAL;
      nibble_width: frame_steps = `BBP_STEPS_NIBBLE;
      default: frame_steps = `BBP_STEPS_BYTE;
    endcase
  endfunction : frame_steps

  function automatic logic [3:0] step_bits(input bbp_width_t w);
    unique case (w)
      serial_width: step_bits = `BBP_BITS_SERIAL;
      nibble_width: step_bits = `BBP_BITS_NIBBLE;
      default: step_bits = `BBP_BITS_BYTE;
    endcase
  endfunction : step_bits

  function automatic logic link_used(input bbp_width_t w, input logic [1:0] k);
    unique case (w)
      serial_width: link_used = (k < `BBP_LINKS_SERIAL);
      nibble_width: link_used = (k < `BBP_LINKS_NIBBLE);
      default: link_used = (k < `BBP_LINKS_BYTE);
    endcase
  endfunction : link_used

  function automatic logic [`BBP_SAMPLE_W-1:0] shift_in(input logic [`BBP_SAMPLE_W-1:0] sh,
      input logic [`BBP_STEP_W-1:0] b, input bbp_width_t w);
    logic [`BBP_SAMPLE_W-1:0] top;
    top = {b, {(`BBP_SAMPLE_W-`BBP_STEP_W){1'b0}}};
    shift_in = (sh >> step_bits(w)) | (top << (4'h9 - step_bits(w)));
  endfunction : shift_in

  // ----------------------------------------------------------------
  // lane mapping per width
  // ----------------------------------------------------------------
  function automatic logic [`BBP_LANES-1:0] lane_pack(input bbp_width_t w, input bbp_step_t d,
      input logic [`BBP_LINKS-1:0] s, input logic [`BBP_LINKS-1:0] c);
    unique case (w)
      serial_width: lane_pack = {c[2], s[2], d[2][1:0], c[1], s[1], d[1][1:0], c[0], s[0], d[0][1:0]};
      nibble_width: lane_pack = {d[1][3:0], c[1], s[1], d[0][3:2], c[0], s[0], d[0][1:0]};
      default: lane_pack = {d[0][8:5], c[0], s[0], d[0][4:3], 1'b0, d[0][2:0]};
    endcase
  endfunction : lane_pack

  function automatic logic [`BBP_STEP_W-1:0] lane_data(input bbp_width_t w, input logic [`BBP_LANES-1:0] l,
      input logic [1:0] k);
    unique case (w)
      serial_width: lane_data = {7'h00, l[{k, 2'h1}], l[{k, 2'h0}]};
      nibble_width: lane_data = (k == 2'h0) ? {5'h00, l[5:4], l[1:0]} : {5'h00, l[11:8]};
      default: lane_data = {l[11:8], l[5:4], l[2:0]};
    endcase
  endfunction : lane_data

  function automatic logic lane_clk(input bbp_width_t w, input logic [`BBP_LANES-1:0] l, input logic [1:0] k);
    lane_clk = (w == byte_width) ? l[7] : l[{k, 2'h3}];
  endfunction : lane_clk

  function automatic logic lane_sync(input bbp_width_t w, input logic [`BBP_LANES-1:0] l, input logic [1:0] k);
    lane_sync = (w == byte_width) ? l[6] : l[{k, 2'h2}];
  endfunction : lane_sync

  function automatic logic mode_clk_bad(input bbp_mode_t m, input logic [`BBP_FREQ_W-1:0] mhz);
    mode_clk_bad = ((m == half_rate_centred_mode) && (mhz > `BBP_HALF_MAX_MHZ)) ||
                   ((m == single_rate_centred_mode) && (mhz > `BBP_SINGLE_MAX_MHZ)) ||
                   ((m != edge_aligned_mode) && (mhz > `BBP_EDGE_ONLY_MHZ));
  endfunction : mode_clk_bad
endpackage : bbp_pkg

//--- bbp_link_if.sv
// lane bundle between the baseband device end and the baseband processor end
`timescale 1ns/1ps
`include "bbp_consts.svh"
interface bbp_link_if;
  logic [`BBP_LANES-1:0] in_lane;
  logic [`BBP_LANES-1:0] out_lane;
  modport dev (input in_lane, output out_lane);
  modport host (output in_lane, input out_lane);
endinterface : bbp_link_if

//--- bbp_dev.sv
// device end of the baseband port: uplink serializer and downlink deserializer
`timescale 1ns/1ps
`include "bbp_consts.svh"
module bbp_dev (
  // clocks and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  // configuration
  input wire logic cfg_en_i,
  input wire bbp_pkg::bbp_mode_t cfg_mode_i,
  input wire bbp_pkg::bbp_width_t cfg_width_i,
  input wire logic [`BBP_FREQ_W-1:0] cfg_clk_mhz_i,
  output logic cfg_err_o,
  output logic cfg_active_o,
  // uplink samples
  input wire logic tx_valid_i,
  input wire bbp_pkg::bbp_frame_t tx_data_i,
  output logic tx_ready_o,
  // downlink samples
  output bbp_pkg::bbp_frame_t rx_data_o,
  output logic [`BBP_LINKS-1:0] rx_valid_o,
  // lanes
  bbp_link_if.dev link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bbp_pkg::bbp_dev_ref_t r_r;
  bbp_pkg::bbp_dev_ref_t r_nxt;
  bbp_pkg::bbp_dev_lnk_t k_r;
  bbp_pkg::bbp_dev_lnk_t k_nxt;
  logic [1:0] lrst_r;
  logic cfg_bad;
  logic ev_d;
  logic ev_c;
  logic act_v;
  logic first_v;
  bbp_pkg::bbp_frame_t sh_v;
  bbp_pkg::bbp_frame_t rsh_v;
  logic [`BBP_LINKS-1:0][4:0] rcnt_v;

  // ----------------------------------------------------------------
  // reference domain: configuration, uplink hand-off, downlink capture
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    rsh_v = r_r.rsh;
    rcnt_v = r_r.rcnt;
    r_nxt.ack_s1 = k_r.ack;
    r_nxt.ack_s2 = r_r.ack_s1;
    cfg_bad = bbp_pkg::mode_clk_bad(cfg_mode_i, cfg_clk_mhz_i);
    if (!r_r.en) begin
      // mode and width only follow the inputs while the port is off
      r_nxt.mode = cfg_mode_i;
      r_nxt.width = cfg_width_i;
      if ((cfg_mode_i != r_r.mode) || (cfg_width_i != r_r.width)) begin
        r_nxt.settle = 6'h00;
      end else if (r_r.settle != `BBP_CFG_SETTLE) begin
        r_nxt.settle = r_r.settle + 6'h01;
      end
      // settle lets the link domain see stable settings before enable lands
      r_nxt.err = cfg_en_i && cfg_bad;
      r_nxt.en = cfg_en_i && !cfg_bad && (r_r.settle == `BBP_CFG_SETTLE) &&
                 (cfg_mode_i == r_r.mode) && (cfg_width_i == r_r.width);
    end else if (!cfg_en_i) begin
      r_nxt.en = 1'b0;
    end
    // uplink word hand-off by toggle; hold stays put until the ack returns
    if (r_r.rdy && tx_valid_i) begin
      r_nxt.hold = tx_data_i;
      r_nxt.req = ~r_r.req;
    end
    r_nxt.rdy = r_nxt.en && (r_nxt.req == r_nxt.ack_s2);
    // downlink lanes come from another clock: two flops, then edge compare
    r_nxt.in_s1 = link.in_lane;
    r_nxt.in_s2 = r_r.in_s1;
    r_nxt.in_prev = r_r.in_s2;
    r_nxt.rvld = '0;
    for (int i = 0; i < `BBP_LINKS; i++) begin
      if (r_r.en && bbp_pkg::link_used(r_r.width, 2'(i)) &&
          (bbp_pkg::lane_clk(r_r.width, r_r.in_s2, 2'(i)) !=
           bbp_pkg::lane_clk(r_r.width, r_r.in_prev, 2'(i)))) begin
        if (bbp_pkg::lane_sync(r_r.width, r_r.in_s2, 2'(i))) begin
          rsh_v[i] = bbp_pkg::shift_in('0, bbp_pkg::lane_data(r_r.width, r_r.in_s2, 2'(i)), r_r.width);
          rcnt_v[i] = 5'h01;
        end else if (r_r.rcnt[i] != 5'h00) begin
          rsh_v[i] = bbp_pkg::shift_in(r_r.rsh[i], bbp_pkg::lane_data(r_r.width, r_r.in_s2, 2'(i)), r_r.width);
          rcnt_v[i] = r_r.rcnt[i] + 5'h01;
        end
        if (rcnt_v[i] == bbp_pkg::frame_steps(r_r.width)) begin
          r_nxt.rdat[i] = rsh_v[i];
          r_nxt.rvld[i] = 1'b1;
          rcnt_v[i] = 5'h00;
        end
      end
    end
    if (!r_r.en) begin
      rcnt_v = '0;
    end
    r_nxt.rsh = rsh_v;
    r_nxt.rcnt = rcnt_v;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // link domain: outgoing clock, sync and data lanes
  // ----------------------------------------------------------------
  // two link edges form one internal cycle: q[0]==0 is its rising edge
  always_comb begin
    k_nxt = k_r;
    ev_d = 1'b0;
    ev_c = 1'b0;
    act_v = k_r.act;
    first_v = 1'b0;
    sh_v = k_r.sh;
    k_nxt.en_s1 = r_r.en;
    k_nxt.en_s2 = k_r.en_s1;
    k_nxt.mode_s1 = r_r.mode;
    k_nxt.mode_s2 = k_r.mode_s1;
    k_nxt.width_s1 = r_r.width;
    k_nxt.width_s2 = k_r.width_s1;
    k_nxt.req_s1 = r_r.req;
    k_nxt.req_s2 = k_r.req_s1;
    if (!k_r.en_s2) begin
      k_nxt.q = 2'h0;
      k_nxt.cnt = 5'h00;
      k_nxt.act = 1'b0;
      k_nxt.d = '0;
      k_nxt.s = '0;
      k_nxt.c = '0;
    end else begin
      k_nxt.q = k_r.q + 2'h1;
      unique case (k_r.mode_s2)
        bbp_pkg::edge_aligned_mode: begin
          ev_d = 1'b1;
          ev_c = 1'b1;
        end
        bbp_pkg::single_rate_centred_mode: begin
          ev_d = ~k_r.q[0];
          ev_c = k_r.q[0];
        end
        bbp_pkg::half_rate_centred_mode: begin
          ev_c = (k_r.q == 2'h0);
          ev_d = (k_r.q == 2'h2);
        end
        default: begin
          ev_d = 1'b0;
          ev_c = 1'b0;
        end
      endcase
      if (ev_d) begin
        if (k_r.cnt == 5'h00) begin
          // a frame starts only on a fresh word; otherwise data and sync lanes idle low
          act_v = (k_r.req_s2 != k_r.ack);
          first_v = act_v;
          sh_v = act_v ? r_r.hold : '0;
          if (act_v) begin
            k_nxt.ack = ~k_r.ack;
          end
        end
        k_nxt.act = act_v;
        for (int i = 0; i < `BBP_LINKS; i++) begin
          k_nxt.d[i] = act_v ? sh_v[i][`BBP_STEP_W-1:0] : '0;
          k_nxt.sh[i] = sh_v[i] >> bbp_pkg::step_bits(k_r.width_s2);
        end
        k_nxt.s = {`BBP_LINKS{first_v}};
        if (!act_v || (k_r.cnt == (bbp_pkg::frame_steps(k_r.width_s2) - 5'h01))) begin
          k_nxt.cnt = 5'h00;
        end else begin
          k_nxt.cnt = k_r.cnt + 5'h01;
        end
      end
      if (ev_c) begin
        k_nxt.c = ~k_r.c;
      end
    end
    k_nxt.lane = bbp_pkg::lane_pack(k_r.width_s2, k_nxt.d, k_nxt.s, k_nxt.c);
  end

  always_ff @(posedge link_clk_i) begin
    lrst_r <= {lrst_r[0], nrst_i};
  end

  always_ff @(posedge link_clk_i) begin
    if (!lrst_r[1]) begin
      k_r <= '0;
    end else begin
      k_r <= k_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.out_lane = k_r.lane;
  assign cfg_err_o = r_r.err;
  assign cfg_active_o = r_r.en;
  assign tx_ready_o = r_r.rdy;
  assign rx_data_o = r_r.rdat;
  assign rx_valid_o = r_r.rvld;

endmodule : bbp_dev

//--- bbp_host.sv
// baseband processor end: drives the incoming lanes, captures the outgoing lanes
`timescale 1ns/1ps
`include "bbp_consts.svh"
module bbp_host (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // configuration
  input wire logic cfg_en_i,
  input wire bbp_pkg::bbp_width_t cfg_width_i,
  output logic cfg_active_o,
  // downlink samples to send
  input wire logic tx_valid_i,
  input wire bbp_pkg::bbp_frame_t tx_data_i,
  output logic tx_ready_o,
  // uplink samples received
  output bbp_pkg::bbp_frame_t rx_data_o,
  output logic [`BBP_LINKS-1:0] rx_valid_o,
  // lanes
  bbp_link_if.host link
);

  bbp_pkg::bbp_host_t h_r;
  bbp_pkg::bbp_host_t h_nxt;
  logic act_v;
  logic first_v;
  bbp_pkg::bbp_frame_t sh_v;
  bbp_pkg::bbp_frame_t rsh_v;
  logic [`BBP_LINKS-1:0][4:0] rcnt_v;

  // ----------------------------------------------------------------
  // divided port clock, centred data, sample capture
  // ----------------------------------------------------------------
  always_comb begin
    h_nxt = h_r;
    act_v = h_r.act;
    first_v = 1'b0;
    sh_v = h_r.sh;
    rsh_v = h_r.rsh;
    rcnt_v = h_r.rcnt;
    h_nxt.en = cfg_en_i;
    if (!h_r.en) begin
      h_nxt.width = cfg_width_i;
    end
    if (tx_valid_i && h_r.rdy) begin
      h_nxt.hold = tx_data_i;
      h_nxt.pend = 1'b1;
    end
    if (!h_r.en) begin
      h_nxt.div = 4'h0;
      h_nxt.cnt = 5'h00;
      h_nxt.act = 1'b0;
      h_nxt.d = '0;
      h_nxt.s = '0;
      h_nxt.c = '0;
    end else begin
      h_nxt.div = h_r.div + 4'h1;
      // data moves halfway between clock edges so both edges sample mid-eye
      if (h_r.div[2:0] == `BBP_HOST_PHASE_CLK) begin
        h_nxt.c = ~h_r.c;
      end
      if (h_r.div[2:0] == `BBP_HOST_PHASE_DAT) begin
        if (h_r.cnt == 5'h00) begin
          act_v = h_r.pend;
          first_v = h_r.pend;
          sh_v = h_r.pend ? h_r.hold : '0;
          // a word taken in this very cycle waits for the next frame
          if (h_r.pend) begin
            h_nxt.pend = 1'b0;
          end
        end
        h_nxt.act = act_v;
        for (int i = 0; i < `BBP_LINKS; i++) begin
          h_nxt.d[i] = act_v ? sh_v[i][`BBP_STEP_W-1:0] : '0;
          h_nxt.sh[i] = sh_v[i] >> bbp_pkg::step_bits(h_r.width);
        end
        h_nxt.s = {`BBP_LINKS{first_v}};
        if (!act_v || (h_r.cnt == (bbp_pkg::frame_steps(h_r.width) - 5'h01))) begin
          h_nxt.cnt = 5'h00;
        end else begin
          h_nxt.cnt = h_r.cnt + 5'h01;
        end
      end
    end
    h_nxt.rdy = h_r.en && !h_nxt.pend;
    h_nxt.lane = bbp_pkg::lane_pack(h_r.width, h_nxt.d, h_nxt.s, h_nxt.c);
    // outgoing lanes of the device: two flops, then sample a fixed delay after each clock edge
    h_nxt.out_s1 = link.out_lane;
    h_nxt.out_s2 = h_r.out_s1;
    h_nxt.out_prev = h_r.out_s2;
    h_nxt.rvld = '0;
    for (int i = 0; i < `BBP_LINKS; i++) begin
      if (h_r.en && bbp_pkg::link_used(h_r.width, 2'(i)) &&
          (bbp_pkg::lane_clk(h_r.width, h_r.out_s2, 2'(i)) != bbp_pkg::lane_clk(h_r.width, h_r.out_prev, 2'(i)))) begin
        h_nxt.dly[i] = `BBP_HOST_SAMPLE_DLY;
      end else if (h_r.dly[i] != 3'h0) begin
        h_nxt.dly[i] = h_r.dly[i] - 3'h1;
      end
      if (h_r.dly[i] == 3'h1) begin
        if (bbp_pkg::lane_sync(h_r.width, h_r.out_s2, 2'(i))) begin
          rsh_v[i] = bbp_pkg::shift_in('0, bbp_pkg::lane_data(h_r.width, h_r.out_s2, 2'(i)), h_r.width);
          rcnt_v[i] = 5'h01;
        end else if (h_r.rcnt[i] != 5'h00) begin
          rsh_v[i] = bbp_pkg::shift_in(h_r.rsh[i], bbp_pkg::lane_data(h_r.width, h_r.out_s2, 2'(i)), h_r.width);
          rcnt_v[i] = h_r.rcnt[i] + 5'h01;
        end
        if (rcnt_v[i] == bbp_pkg::frame_steps(h_r.width)) begin
          h_nxt.rdat[i] = rsh_v[i];
          h_nxt.rvld[i] = 1'b1;
          rcnt_v[i] = 5'h00;
        end
      end
    end
    if (!h_r.en) begin
      rcnt_v = '0;
      h_nxt.dly = '0;
    end
    h_nxt.rsh = rsh_v;
    h_nxt.rcnt = rcnt_v;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign link.in_lane = h_r.lane;
  assign cfg_active_o = h_r.en;
  assign tx_ready_o = h_r.rdy;
  assign rx_data_o = h_r.rdat;
  assign rx_valid_o = h_r.rvld;

endmodule : bbp_host

//--- bbp_link_props.sv
// checker for the lanes between the device end and the processor end
`timescale 1ns/1ps
`include "bbp_consts.svh"
module bbp_link_props (
  // clocks and reset
  input wire logic ref_clk_i,
  input wire logic link_clk_i,
  input wire logic nrst_i,
  // device settings
  input wire bbp_pkg::bbp_mode_t cfg_mode_i,
  input wire bbp_pkg::bbp_width_t cfg_width_i,
  input wire logic cfg_active_o,
  // lanes
  input wire logic [`BBP_LANES-1:0] in_lane,
  input wire logic [`BBP_LANES-1:0] out_lane
);
  // ----
  // link 0 lanes and step length
  // ----
  logic byt;
  logic ck;
  logic ick;
  logic sy;
  logic [`BBP_LANES-1:0] msk;
  logic [6:0] len;
  logic [6:0] run_r;
  logic [6:0] gap_r;
  logic ck_r;
  logic seen_r;
  assign byt = (cfg_width_i == bbp_pkg::byte_width);
  assign ck = byt ? out_lane[7] : out_lane[3];
  assign ick = byt ? in_lane[7] : in_lane[3];
  assign sy = byt ? out_lane[6] : out_lane[2];
  assign msk = byt ? 12'hF77 : (cfg_width_i == bbp_pkg::nibble_width) ? 12'h037 : 12'h007;
  // step length in reference cycles: one, two or four link edges of 16 cycles each
  assign len = (cfg_mode_i == bbp_pkg::edge_aligned_mode) ? 7'h10 :
               (cfg_mode_i == bbp_pkg::single_rate_centred_mode) ? 7'h20 : 7'h40;
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      run_r <= 7'h00;
      gap_r <= 7'h00;
      ck_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      run_r <= sy ? run_r + 7'h01 : 7'h00;
      gap_r <= (ck != ck_r) ? 7'h01 : gap_r + 7'h01;
      ck_r <= ck;
      seen_r <= cfg_active_o && (seen_r || (ck != ck_r));
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_sync_run_len: assert property (cfg_active_o && $fell(sy) |-> run_r == len)
    else $error("sync lane high for a wrong span");
  chk_clk_gap_len: assert property (cfg_active_o && seen_r && $changed(ck) |-> gap_r == len)
    else $error("port clock toggles at a wrong spacing");
  chk_centre_hold: assert property (
    cfg_active_o && cfg_mode_i != bbp_pkg::edge_aligned_mode && $changed(ck)
    |-> $stable(out_lane & msk) ##1 $stable(out_lane & msk)[*3])
    else $error("data moved near a centred clock edge");
  chk_edge_together: assert property (
    cfg_active_o && cfg_mode_i == bbp_pkg::edge_aligned_mode && $changed(out_lane & msk) |-> $changed(ck))
    else $error("data moved without a clock edge");
  chk_byte_spare_out: assert property (cfg_active_o && byt |-> out_lane[3] == 1'b0)
    else $error("spare outgoing lane driven in byte width");
  chk_byte_spare_in: assert property (cfg_active_o && byt |-> in_lane[3] == 1'b0)
    else $error("spare incoming lane driven in byte width");
  chk_in_mid_data: assert property (cfg_active_o && $changed(ick) |-> $stable(in_lane & msk)[*4])
    else $error("incoming data moved near its clock edge");
  chk_settle_first: assert property ($rose(cfg_active_o) |->
    $past(cfg_mode_i, 45) == cfg_mode_i && $past(cfg_width_i, 45) == cfg_width_i)
    else $error("port enabled before settings settled");
endmodule : bbp_link_props

//--- test_baseband_ddr_lvds_port.sv
// self-checking bench joining the device end and the processor end of the baseband port
`timescale 1ns/1ps
`include "bbp_consts.svh"
module test_baseband_ddr_lvds_port;
  logic ref_clk;
  logic link_clk;
  logic nrst;
  logic en;
  bbp_pkg::bbp_mode_t mode;
  bbp_pkg::bbp_width_t width;
  logic [`BBP_FREQ_W-1:0] mhz;
  logic up_valid;
  logic dn_valid;
  bbp_pkg::bbp_frame_t up_data;
  bbp_pkg::bbp_frame_t dn_data;
  bbp_pkg::bbp_frame_t dev_rx;
  bbp_pkg::bbp_frame_t host_rx;
  logic [`BBP_LINKS-1:0] dev_rxv;
  logic [`BBP_LINKS-1:0] host_rxv;
  logic dev_err;
  logic dev_act;
  logic host_act;
  logic up_ready;
  logic dn_ready;
  logic [11:0] prev_lanes [2];
  // model: 0/2 frames awaited at processor/device, 1/3 first steps awaited on out/in lanes
  logic [35:0] q [4][3][$];
  int num_errors = 0;
  int n_compared = 0;
  int seed = 22046;
  int cm [5] = '{2, 2, 1, 1, 0};
  int cf [5] = '{155, 156, 250, 251, 500};
  int ce [5] = '{0, 1, 0, 1, 0};
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #80 link_clk = ~link_clk;
  end
  bbp_link_if i_bbp_link_if ();
  bbp_dev i_bbp_dev (.ref_clk_i(ref_clk), .nrst_i(nrst), .link_clk_i(link_clk), .cfg_en_i(en), .cfg_mode_i(mode),
    .cfg_width_i(width), .cfg_clk_mhz_i(mhz), .cfg_err_o(dev_err), .cfg_active_o(dev_act), .tx_valid_i(up_valid),
    .tx_data_i(up_data), .tx_ready_o(up_ready), .rx_data_o(dev_rx), .rx_valid_o(dev_rxv), .link(i_bbp_link_if.dev));
  bbp_host i_bbp_host (.ref_clk_i(ref_clk), .nrst_i(nrst), .cfg_en_i(en), .cfg_width_i(width),
    .cfg_active_o(host_act), .tx_valid_i(dn_valid), .tx_data_i(dn_data), .tx_ready_o(dn_ready),
    .rx_data_o(host_rx), .rx_valid_o(host_rxv), .link(i_bbp_link_if.host));
  bbp_link_props i_bbp_link_props (.ref_clk_i(ref_clk), .link_clk_i(link_clk), .nrst_i(nrst), .cfg_mode_i(mode),
    .cfg_width_i(width), .cfg_active_o(dev_act), .in_lane(i_bbp_link_if.in_lane), .out_lane(i_bbp_link_if.out_lane));
  // ----
  // helpers
  // ----
  task automatic check(input logic [35:0] seen, input logic [35:0] expd);
    n_compared++;
    if (seen !== expd) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  function automatic logic [35:0] pop(input int a, input int k);
    if (q[a][k].size() == 0) return 'x;
    return q[a][k].pop_front();
  endfunction : pop
  function automatic int pending();
    return q[0][0].size() + q[0][1].size() + q[0][2].size() + q[2][0].size() + q[2][1].size() + q[2][2].size();
  endfunction : pending
  function automatic logic [8:0] step_of(input logic [11:0] l, input int k);
    case (width)
      bbp_pkg::serial_width: return {7'h00, l[4 * k + 1], l[4 * k]};
      bbp_pkg::nibble_width: return (k == 0) ? {5'h00, l[5], l[4], l[1], l[0]} : {5'h00, l[11:8]};
      default: return {l[11:8], l[5:4], l[2:0]};
    endcase
  endfunction : step_of
  task automatic send(input int dn);
    logic [127:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(posedge ref_clk);
    if (dn == 1) begin
      dn_valid <= 1'b1;
      dn_data <= r[107:0];
    end else begin
      up_valid <= 1'b1;
      up_data <= r[107:0];
    end
    for (int i = 0; i < 2000; i++) begin
      @(posedge ref_clk);
      if (((dn == 1) ? dn_ready : up_ready) === 1'b1) break;
    end
    for (int k = 0; k < 3 - int'(width); k++) begin
      q[2 * dn][k].push_back(r[36 * k +: 36]);
      q[2 * dn + 1][k].push_back(r[36 * k +: 36]);
    end
    if (dn == 1) dn_valid <= 1'b0;
    else up_valid <= 1'b0;
  endtask : send
  task automatic setup(input int m, input int w, input int f);
    @(posedge ref_clk);
    en <= 1'b0;
    repeat (100) @(posedge ref_clk);
    mode <= bbp_pkg::bbp_mode_t'(m);
    width <= bbp_pkg::bbp_width_t'(w);
    mhz <= 10'(f);
    @(posedge ref_clk);
    en <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : setup
  // ----
  // monitors of the lanes and of both receive sides
  // ----
  always @(posedge ref_clk) begin
    logic [11:0] l;
    int s;
    for (int d = 0; d < 2; d++) begin
      l = (d == 1) ? i_bbp_link_if.in_lane : i_bbp_link_if.out_lane;
      for (int k = 0; k < 3 - int'(width); k++) begin
        s = (width == bbp_pkg::byte_width) ? 6 : 4 * k + 2;
        if (l[s] === 1'b1 && prev_lanes[d][s] === 1'b0)
          check({27'h0, step_of(l, k)}, pop(2 * d + 1, k) & {27'h0, step_of(12'hFFF, k)});
      end
      prev_lanes[d] <= l;
    end
    for (int k = 0; k < 3; k++) begin
      if (host_rxv[k] === 1'b1) check(host_rx[k], pop(0, k));
      if (dev_rxv[k] === 1'b1) check(dev_rx[k], pop(2, k));
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    nrst = 1'b0;
    en = 1'b0;
    mode = bbp_pkg::edge_aligned_mode;
    width = bbp_pkg::serial_width;
    mhz = 10'h064;
    up_valid = 1'b0;
    dn_valid = 1'b0;
    up_data = '0;
    dn_data = '0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      setup(cm[i], 0, cf[i]);
      check(36'(dev_err), 36'(ce[i]));
      repeat (60) @(posedge ref_clk);
      check(36'(dev_act), 36'(1 - ce[i]));
    end
    for (int w = 0; w < 3; w++) begin
      for (int m = 0; m < 3; m++) begin
        setup(m, w, 100);
        repeat (60) @(posedge ref_clk);
        check(36'(dev_act), 36'h1);
        check(36'(host_act), 36'h1);
        fork
          begin send(0); send(0); end
          begin send(1); send(1); end
        join
        for (int i = 0; i < 4000 && pending() > 0; i++) @(posedge ref_clk);
        check(36'(pending()), 36'h0);
      end
    end
    final_report();
  end
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
endmodule : test_baseband_ddr_lvds_port
